// File: gpk_pin_param.sv
module gpk_pin_param (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [23:0]      pinConfigLock,
  output logic [23:0]      driveStrengthSelect,
  output logic [23:0]      pullupDisable,
  output logic             analogInputSelect,
  output logic             spiSelect,
  output logic             i2cSelect
);

  logic [23:0] paramFf [3];
  logic [23:0] nxtParam [3];
  logic [31:0] rdataFf;
  logic [31:0] nxtRdata;
  logic        errFf;
  logic        nxtErr;
  logic        wrStb;
  logic        rdStb;
  logic [1:0]  altCtrl;

  function automatic logic [1:0] portIndex(input logic [31:0] addr);
    unique case (addr)
      gpk_pkg::ADDR_PORT0_PARAM: portIndex = 2'd0;
      gpk_pkg::ADDR_PORT1_PARAM: portIndex = 2'd1;
      gpk_pkg::ADDR_PORT2_PARAM: portIndex = 2'd2;
      default:                   portIndex = 2'd3;
    endcase
  endfunction : portIndex

  // ----------------------------------------------------------------
  // APB slave, one wait-free access phase
  // ----------------------------------------------------------------
  assign wrStb   = psel && !penable && pwrite;
  assign rdStb   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign prdata  = rdataFf;
  assign pslverr = errFf;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      nxtParam[i] = paramFf[i];
    end
    nxtRdata = rdataFf;
    nxtErr   = errFf;
    if (psel && !penable) begin
      nxtRdata = 32'h00000000;
      nxtErr   = 1'b0;
      if (portIndex(paddr) != 2'd3) begin
        if (wrStb) begin
          nxtParam[portIndex(paddr)] = pwdata[23:0];
        end else if (rdStb) begin
          nxtRdata = {8'h00, paramFf[portIndex(paddr)]};
        end
      end else if (paddr == gpk_pkg::ADDR_ALT_FUNC_CTRL) begin
        nxtRdata = {30'h00000000, altCtrl};
      end else if (paddr != gpk_pkg::ADDR_UNLOCK_FIRST &&
                   paddr != gpk_pkg::ADDR_UNLOCK_SECOND) begin
        nxtErr = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        paramFf[i] <= gpk_pkg::PARAM_RESET;
      end
      rdataFf <= 32'h00000000;
      errFf   <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        paramFf[i] <= nxtParam[i];
      end
      rdataFf <= nxtRdata;
      errFf   <= nxtErr;
    end
  end

  gpk_key_seq u_key (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wrStb   (wrStb),
    .wrAddr  (paddr),
    .wrData  (pwdata),
    .altCtrl (altCtrl)
  );

  // ----------------------------------------------------------------
  // Pad controls
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      pinConfigLock[p*8 +: 8]       = paramFf[p][gpk_pkg::LOCK_LSB +: 8];
      driveStrengthSelect[p*8 +: 8] = paramFf[p][gpk_pkg::DRIVE_LSB +: 8];
      pullupDisable[p*8 +: 8]       = paramFf[p][gpk_pkg::PULL_LSB +: 8];
    end
    pullupDisable[gpk_pkg::FIXED_PULL_PIN] = 1'b0;
  end

  assign analogInputSelect = altCtrl[gpk_pkg::ANALOG_BIT];
  assign i2cSelect = !altCtrl[gpk_pkg::ANALOG_BIT] && altCtrl[gpk_pkg::SERIAL_BIT];
  assign spiSelect = !altCtrl[gpk_pkg::ANALOG_BIT] && !altCtrl[gpk_pkg::SERIAL_BIT];

endmodule : gpk_pin_param

// File: gpk_pkg.sv
// Summary of operation
// - The pull-up of port 0 pin 2 stays active whatever its pull-up disable bit holds.
// - Lock bits 23:16 only drive pinConfigLock; the parameter and control registers take writes whatever they hold.
// - Drive strength bits 15:8 go to the pad drivers, 0 for 2 mA and 1 for 4 mA.
// - Pull-up disable bits 7:0 drive the pad pull-up control, 1 disabling the pull-up.
// - Control bit 1 picks SPI (0) or I2C (1) for port 0 pins 0 to 3, only while bit 0 is 0.
// - Control bit 0 routes port 0 pins 0 to 3 to analog inputs when 1, and both bits reset to 0.
package gpk_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_UNLOCK_FIRST  = 32'hFFFF0464;
  localparam logic [31:0] ADDR_ALT_FUNC_CTRL = 32'hFFFF0468;
  localparam logic [31:0] ADDR_UNLOCK_SECOND = 32'hFFFF046C;
  localparam logic [31:0] ADDR_PORT0_PARAM   = 32'hFFFF0D2C;
  localparam logic [31:0] ADDR_PORT1_PARAM   = 32'hFFFF0D3C;
  localparam logic [31:0] ADDR_PORT2_PARAM   = 32'hFFFF0D4C;

  // ----------------------------------------------------------------
  // Field layout and values
  // ----------------------------------------------------------------
  localparam int          LOCK_LSB       = 16;
  localparam int          DRIVE_LSB      = 8;
  localparam int          PULL_LSB       = 0;
  localparam int          PARAM_WIDTH    = 24;
  localparam int          ALT_WIDTH      = 2;
  localparam int          ANALOG_BIT     = 0;
  localparam int          SERIAL_BIT     = 1;
  localparam int          FIXED_PULL_PIN = 2;
  localparam logic [15:0] KEY_FIRST      = 16'h0007;
  localparam logic [15:0] KEY_SECOND     = 16'h0013;
  localparam logic [23:0] PARAM_RESET    = 24'h000000;
  localparam logic [1:0]  ALT_RESET      = 2'h0;

  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_OPEN  = 2'b01,
    KEY_STAGE = 2'b11
  } gpk_key_e;

endpackage : gpk_pkg

// File: gpk_key_seq.sv
module gpk_key_seq (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       wrStb,
  input  wire logic [31:0] wrAddr,
  input  wire logic [31:0] wrData,
  output logic [1:0]      altCtrl
);

  gpk_pkg::gpk_key_e stateFf;
  gpk_pkg::gpk_key_e nxtState;
  logic [1:0]        stageFf;
  logic [1:0]        nxtStage;
  logic [1:0]        altFf;
  logic [1:0]        nxtAlt;

  // ----------------------------------------------------------------
  // Unlock sequence: key, value, key on consecutive writes
  // ----------------------------------------------------------------
  always_comb begin
    nxtState = stateFf;
    nxtStage = stageFf;
    nxtAlt   = altFf;
    if (wrStb) begin
      nxtState = gpk_pkg::KEY_IDLE;
      unique case (stateFf)
        gpk_pkg::KEY_IDLE: ;
        gpk_pkg::KEY_OPEN: begin
          if (wrAddr == gpk_pkg::ADDR_ALT_FUNC_CTRL) begin
            nxtStage = wrData[1:0];
            nxtState = gpk_pkg::KEY_STAGE;
          end
        end
        gpk_pkg::KEY_STAGE: begin
          if (wrAddr == gpk_pkg::ADDR_UNLOCK_SECOND && wrData[15:0] == gpk_pkg::KEY_SECOND) begin
            nxtAlt = stageFf;
          end
        end
        default: ;
      endcase
      if (wrAddr == gpk_pkg::ADDR_UNLOCK_FIRST && wrData[15:0] == gpk_pkg::KEY_FIRST) begin
        nxtState = gpk_pkg::KEY_OPEN;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateFf <= gpk_pkg::KEY_IDLE;
      stageFf <= gpk_pkg::ALT_RESET;
      altFf   <= gpk_pkg::ALT_RESET;
    end else begin
      stateFf <= nxtState;
      stageFf <= nxtStage;
      altFf   <= nxtAlt;
    end
  end

  assign altCtrl = altFf;

endmodule : gpk_key_seq

// File: gpk_pin_param_assertions.sv
module gpk_pin_param_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [23:0] pinConfigLock,
  input wire logic [23:0] driveStrengthSelect,
  input wire logic [23:0] pullupDisable,
  input wire logic        analogInputSelect,
  input wire logic        spiSelect,
  input wire logic        i2cSelect
);
  // ----
  // Port and control properties
  // ----
  wire p0Wr = psel && !penable && pwrite && paddr == 32'hFFFF0D2C;
  wire k2Wr = psel && !penable && pwrite && paddr == 32'hFFFF046C && pwdata[15:0] == 16'h0013;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_lock; p0Wr |=> pinConfigLock[7:0] == $past(pwdata[23:16]); endproperty
  a_lock: assert property (p_lock) else $error("lock bits wrong");
  property p_drv; p0Wr |=> driveStrengthSelect[7:0] == $past(pwdata[15:8]); endproperty
  a_drv: assert property (p_drv) else $error("drive bits wrong");
  property p_pull; p0Wr |=> pullupDisable[7:0] == ($past(pwdata[7:0]) & 8'hFB); endproperty
  a_pull: assert property (p_pull) else $error("pull bits wrong");
  property p_pu; !pullupDisable[2]; endproperty
  a_pu: assert property (p_pu) else $error("pin 2 pull-up off");
  property p_sel; !analogInputSelect |-> spiSelect != i2cSelect; endproperty
  a_sel: assert property (p_sel) else $error("serial select wrong");
  property p_ana; analogInputSelect |-> !spiSelect && !i2cSelect; endproperty
  a_ana: assert property (p_ana) else $error("analog select wrong");
  property p_key; $changed({analogInputSelect, i2cSelect}) |-> $past(k2Wr); endproperty
  a_key: assert property (p_key) else $error("control changed unkeyed");
endmodule : gpk_pin_param_chk

bind gpk_pin_param gpk_pin_param_chk u_chk (.sys_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pinConfigLock, .driveStrengthSelect, .pullupDisable,
  .analogInputSelect, .spiSelect, .i2cSelect);

// File: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic [23:0] pinConfigLock, driveStrengthSelect, pullupDisable, mPar [3];
  logic [1:0]  mCtl, pend;
  logic        pready, pslverr, analogInputSelect, spiSelect, i2cSelect;
  int          failures = 0, total_checks = 0, seed = 36, ks = 0;
  logic [31:0] tq [18] = '{32'hFFFF0468, 2, 32'hFFFF0464, 7, 32'hFFFF0D3C, 5,
    32'hFFFF0468, 2, 32'hFFFF046C, 32'h13, 32'hFFFF0D00, 9,
    32'hFFFF0464, 6, 32'hFFFF0468, 2, 32'hFFFF046C, 32'h13};
  gpk_pin_param u_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pinConfigLock, .driveStrengthSelect, .pullupDisable,
    .analogInputSelect, .spiSelect, .i2cSelect);
  always #10 sys_clk = ~sys_clk;
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [31:0] x, g);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("Error %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic cmp();
    for (int p = 0; p < 3; p++) begin
      chk("lock", mPar[p][23:16], pinConfigLock[p*8+:8]);
      chk("drive", mPar[p][15:8], driveStrengthSelect[p*8+:8]);
      chk("pull", mPar[p][7:0] & (p ? 8'hFF : 8'hFB), pullupDisable[p*8+:8]);
    end
    chk("ana", mCtl[0], analogInputSelect);
    chk("spi", !mCtl[0] && !mCtl[1], spiSelect);
    chk("i2c", !mCtl[0] && mCtl[1], i2cSelect);
  endtask : cmp
  task automatic wr(input logic [31:0] a, d);
    apb(1, a, d);
    for (int p = 0; p < 3; p++) if (a == 32'hFFFF0D2C + 16 * p) mPar[p] = d[23:0];
    if (ks == 2 && a == 32'hFFFF046C && d[15:0] == 16'h0013) mCtl = pend;
    if (ks == 1 && a == 32'hFFFF0468) pend = d[1:0];
    ks = (a == 32'hFFFF0464 && d[15:0] == 16'h0007) ? 1 : (ks == 1 && a == 32'hFFFF0468) ? 2 : 0;
    cmp();
  endtask : wr
  task automatic rd(input logic [31:0] a, x, input logic er);
    apb(0, a, 0);
    chk("err", er, e);
    if (!er) chk("rdata", x, r);
  endtask : rd
  task automatic mrst();
    mPar = '{3{24'h0}};
    mCtl = 0;
    ks = 0;
  endtask : mrst
  initial begin
    mrst();
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    cmp();
    wr(32'hFFFF0D2C, 32'hFFFFFFFF);
    for (int i = 0; i < 12; i++) begin
      wr(32'hFFFF0D2C + 16 * (i % 3), $random(seed));
      wr(32'hFFFF0D20 + 16 * (i % 3), 0);
      rd(32'hFFFF0D2C + 16 * (i % 3), {8'h0, mPar[i % 3]}, 0);
    end
    for (int v = 0; v < 4; v++) begin
      wr(32'hFFFF0464, 32'h7);
      wr(32'hFFFF0468, v);
      rd(32'hFFFF0468, {30'h0, mCtl}, 0);
      wr(32'hFFFF046C, 32'h13);
      rd(32'hFFFF0468, v, 0);
    end
    foreach (tq[j]) if (j % 2 == 0) wr(tq[j], tq[j + 1]);
    rd(32'hFFFF0468, {30'h0, mCtl}, 0);
    rd(32'hFFFF0D00, 0, 1);
    rd(32'hFFFF0464, 0, 0);
    rst_n <= 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    mrst();
    cmp();
    rd(32'hFFFF0468, 0, 0);
    rd(32'hFFFF0D2C, 0, 0);
    print_verdict();
  end
endmodule : tb_top
